// ==== logic/aes_pkg.sv ====
// package for the adaptive element shuffler control block
// assumes one converter-rate clock and a simple register write/read port
package aes_pkg;

    localparam logic [11:0] OFS_RATES_ONE_TWO    = 12'h342;
    localparam logic [11:0] OFS_RATES_THREE_FOUR = 12'h343;
    localparam logic [7:0]  RST_RATES_ONE_TWO    = 8'hF5;
    localparam logic [7:0]  RST_RATES_THREE_FOUR = 8'hFF;
    localparam logic [3:0]  THR_NONE             = 4'hF;
    localparam logic [3:0]  THR_ALWAYS           = 4'h0;
    localparam int          LO_NIB               = 0;
    localparam int          HI_NIB               = 4;
    localparam int          HOLD_CYCLES          = 16;
    localparam int          SEQ_LEN              = 32;
    localparam int          NUM_ELEM             = 16;
    localparam logic [4:0]  LFSR_SEED            = 5'h10;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } aes_reg_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [7:0]  rdata;
    } aes_reg_rsp_t;

endpackage : aes_pkg

// ==== logic/aes_shuffler.sv ====
// adaptive element shuffler control: threshold watch, hold timer, rate divider
// and pseudorandom element rotation; assumes quantizer code arrives on clk
`timescale 1ns/1ps
`default_nettype none
module aes_shuffler #(
    parameter int HOLD = aes_pkg::HOLD_CYCLES,
    parameter int NE   = aes_pkg::NUM_ELEM
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic signed [4:0]     quant_code,
    input  wire aes_pkg::aes_reg_req_t reg_req,
    output var  aes_pkg::aes_reg_rsp_t reg_rsp,
    output logic                       shuffle_active,
    output logic                       shuffle_strobe,
    output logic [1:0]                 shuffle_rate_factor,
    output logic [4:0]                 element_offset
);

    // whole block state: one comb process builds next_st, one flop bank holds st
    typedef struct packed {
        // register copies
        logic [7:0]  rates_one_two;
        logic [7:0]  rates_three_four;
        // threshold watch and hold timer
        logic [15:0] hold_cnt;
        logic        active;
        // rate divider and element sequence
        logic [1:0]  div_cnt;
        logic        strobe;
        logic [4:0]  lfsr;
        logic [4:0]  offset;
        // read answer
        logic        rvalid;
        logic [7:0]  rdata;
    } aes_state_t;

    aes_state_t st;
    aes_state_t next_st;

    // magnitude of a -8..+8 code fits in five bits without overflow
    function automatic logic [4:0] code_mag(input logic signed [4:0] code);
        logic [4:0] m;

        if (code[4]) begin
            m = 5'(-code);
        end else begin
            m = 5'(code);
        end
        return m;
    endfunction : code_mag

    // shared by the write and the read decode
    function automatic logic addr_hit(
        input logic [11:0] addr,
        input logic [11:0] ofs
    );
        return addr == ofs;
    endfunction : addr_hit

    // 5-bit maximal lfsr has period 31; the extra all-zero step after 0x01 makes 32
    function automatic logic [4:0] lfsr_step(input logic [4:0] cur);
        logic [4:0] nxt;

        if (cur == 5'h01) begin
            nxt = 5'h00;
        end else if (cur == 5'h00) begin
            nxt = 5'h10;
        end else begin
            nxt = {cur[0] ^ cur[2], cur[4:1]};
        end
        return nxt;
    endfunction : lfsr_step

    // the four threshold nibbles in rate order one..four
    wire logic [15:0] all_nib;
    wire logic [3:0]  nib_thr [4];
    wire logic [3:0]  nib_used;

    logic [1:0]       rate_idx;
    logic [3:0]       thr;
    logic             thr_used;

    logic [4:0]       mag;
    logic             hit;
    logic             hold_done;
    logic             wrap;

    assign all_nib = {st.rates_three_four, st.rates_one_two};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_nib
            assign nib_thr[g]  = all_nib[4 * g +: 4];
            assign nib_used[g] = (all_nib[4 * g +: 4] != aes_pkg::THR_NONE);
        end
    endgenerate

    // lowest used rate wins if the host leaves more than one nibble programmed
    always_comb begin
        rate_idx = 2'h0;
        thr      = aes_pkg::THR_NONE;
        for (int i = 3; i >= 0; i--) begin
            if (nib_used[i]) begin
                rate_idx = 2'(i);
                thr      = nib_thr[i];
            end
        end
    end

    always_comb begin
        thr_used  = (thr != aes_pkg::THR_NONE);
        mag       = code_mag(quant_code);
        // 0xF never triggers, which also gives the all-ones disable
        hit       = thr_used && ({1'b0, thr} <= mag);
        hold_done = (st.hold_cnt == 16'h0000);
        wrap      = (st.div_cnt >= rate_idx);
    end

    always_comb begin
        next_st        = st;
        // pulses default low and are raised below
        next_st.rvalid = 1'b0;
        next_st.strobe = 1'b0;

        // register writes; unmapped addresses are dropped
        if (reg_req.wr) begin
            if (addr_hit(reg_req.addr, aes_pkg::OFS_RATES_ONE_TWO)) begin
                next_st.rates_one_two = reg_req.wdata;
            end
            if (addr_hit(reg_req.addr, aes_pkg::OFS_RATES_THREE_FOUR)) begin
                next_st.rates_three_four = reg_req.wdata;
            end
        end

        // reads return the value held before a same-cycle write
        if (reg_req.rd) begin
            next_st.rvalid = 1'b1;
            if (addr_hit(reg_req.addr, aes_pkg::OFS_RATES_ONE_TWO)) begin
                next_st.rdata = st.rates_one_two;
            end else if (addr_hit(reg_req.addr, aes_pkg::OFS_RATES_THREE_FOUR)) begin
                next_st.rdata = st.rates_three_four;
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        // any new hit reloads the hold timer
        if (hit) begin
            next_st.active   = 1'b1;
            next_st.hold_cnt = 16'(HOLD);
        end else if (!hold_done) begin
            next_st.hold_cnt = st.hold_cnt - 16'h0001;
        end else begin
            next_st.active = 1'b0;
        end

        // divider runs freely and wraps against the live rate, so a rate change applies to the count in progress
        // strobe marks each reshuffle so the dac side can latch the new offset
        if (wrap) begin
            next_st.div_cnt = 2'h0;
            next_st.strobe  = st.active;
        end else begin
            next_st.div_cnt = st.div_cnt + 2'h1;
        end

        if (st.active && wrap) begin
            next_st.lfsr   = lfsr_step(st.lfsr);
            next_st.offset = st.lfsr;
        end else if (!st.active) begin
            // fixed, unrotated element order when idle
            next_st.offset = 5'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // threshold 5 at the every-cycle rate
            st.rates_one_two    <= aes_pkg::RST_RATES_ONE_TWO;
            st.rates_three_four <= aes_pkg::RST_RATES_THREE_FOUR;

            st.hold_cnt         <= 16'h0000;
            st.active           <= 1'b0;
            st.div_cnt          <= 2'h0;
            st.strobe           <= 1'b0;
            st.lfsr             <= aes_pkg::LFSR_SEED;
            st.offset           <= 5'h00;
            st.rvalid           <= 1'b0;
            st.rdata            <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    // rate factor is decoded from the register copies, so it follows a write at once
    assign reg_rsp.rvalid      = st.rvalid;
    assign reg_rsp.rdata       = st.rdata;
    assign shuffle_active      = st.active;
    assign shuffle_strobe      = st.strobe;
    assign shuffle_rate_factor = rate_idx;
    assign element_offset      = st.offset;

endmodule : aes_shuffler
`default_nettype wire

// ==== tb/aes_shuffler_chk.sv ====
// port checker for the shuffler block
// assumes the bench runs it with HOLD of at least 2
`timescale 1ns/1ps
`default_nettype none
module aes_chk #(parameter int HOLD = 2) (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic signed [4:0]     quant_code,
    input wire aes_pkg::aes_reg_req_t reg_req,
    input wire aes_pkg::aes_reg_rsp_t reg_rsp,
    input wire logic                  shuffle_active,
    input wire logic                  shuffle_strobe,
    input wire logic [1:0]            shuffle_rate_factor,
    input wire logic [4:0]            element_offset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RD_ANS: assert property (reg_req.rd |=> reg_rsp.rvalid) else $error("read unanswered");
    AST_RV_CAUSE: assert property (reg_rsp.rvalid |-> $past(reg_req.rd)) else $error("stray rvalid");
    AST_RDATA: assert property (!reg_rsp.rvalid |-> $stable(reg_rsp.rdata)) else $error("rdata moved");
    AST_IDLE_STB: assert property (!shuffle_active && !$past(shuffle_active) |-> !shuffle_strobe)
        else $error("idle strobe");
    AST_OFS: assert property ($changed(element_offset) |-> shuffle_strobe || element_offset == 5'h00)
        else $error("offset moved");
    AST_RATE1: assert property (shuffle_active && $past(shuffle_active) && shuffle_rate_factor == 2'h0
        && $past(shuffle_rate_factor, 2) == 2'h0 |-> shuffle_strobe) else $error("missed strobe");
    AST_GAP4: assert property (shuffle_strobe && shuffle_rate_factor == 2'h3 && $past(shuffle_rate_factor, 8) == 2'h3
        |-> !$past(shuffle_strobe) && !$past(shuffle_strobe, 2) && !$past(shuffle_strobe, 3)) else $error("fast strobe");
    // a drop needs the two cycles before it still active
    AST_HOLD: assert property ($fell(shuffle_active) |-> $past(shuffle_active, 2)) else $error("short hold");
endmodule : aes_chk
bind aes_shuffler aes_chk #(.HOLD(HOLD)) aes_chk_inst (.clk(clk), .rst_b(rst_b), .quant_code(quant_code),
    .reg_req(reg_req), .reg_rsp(reg_rsp), .shuffle_active(shuffle_active), .shuffle_strobe(shuffle_strobe),
    .shuffle_rate_factor(shuffle_rate_factor), .element_offset(element_offset));
`default_nettype wire

// ==== tb/tb_aes_shuffler.sv ====
// register and threshold tests for the shuffler block
// assumes HOLD of 2 and inputs driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t got %h", $time, a); end end
module tb_aes_shuffler;
    logic                  clk = 0;
    logic                  rst_b = 0;
    logic signed [4:0]     quant_code = 0;
    aes_pkg::aes_reg_req_t reg_req = '0;
    aes_pkg::aes_reg_rsp_t rsp;
    logic                  act, stb;
    logic [1:0]            rf;
    logic [4:0]            ofs, o0;
    int                    error_cnt, n_compared, cyc, n;
    always #5 clk = ~clk;
    aes_shuffler #(.HOLD(2)) aes_shuffler_inst (.clk(clk), .rst_b(rst_b), .quant_code(quant_code),
        .reg_req(reg_req), .reg_rsp(rsp), .shuffle_active(act), .shuffle_strobe(stb),
        .shuffle_rate_factor(rf), .element_offset(ofs));
    task automatic cy(input int k);
        repeat (k) @(negedge clk);
    endtask : cy
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge clk) reg_req = '{wr: w, rd: !w, addr: a, wdata: w ? d : 8'h00};
        @(negedge clk) reg_req = '0;
        if (!w) `CHK({rsp.rvalid, rsp.rdata}, {1'b1, d})
    endtask : acc
    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        cy(6);
        rst_b = 1;
        acc(0, 12'h342, 8'hF5);
        acc(0, 12'h343, 8'hFF);
        acc(0, 12'h100, 8'h00);
        quant_code = -5;
        cy(1);
        `CHK(act, 1'b1)
        quant_code = 4;
        cy(2);
        `CHK(act, 1'b1)
        cy(1);
        `CHK(act, 1'b0)
        for (int k = 0; k < 4; k++) begin
            acc(1, 12'h342, k == 0 ? 8'hF0 : k == 1 ? 8'h0F : 8'hFF);
            acc(1, 12'h343, k == 2 ? 8'hF0 : k == 3 ? 8'h0F : 8'hFF);
            cy(3);
            `CHK(rf, k[1:0])
            n = 0;
            o0 = ofs;
            for (int i = 0; i < 48; i++) begin
                cy(1);
                n += stb;
                if (k == 0 && i < 32) `CHK(ofs == o0, i == 31)
            end
            `CHK(n, 48 / (k + 1))
        end
        acc(1, 12'h343, 8'hFF);
        quant_code = 8;
        cy(5);
        `CHK({act, rf}, 3'h0)
        for (int t = 3; t < 9; t++) begin
            acc(1, 12'h342, {4'hF, t[3:0]});
            quant_code = 5'(1 - t);
            cy(4);
            `CHK(act, 1'b0)
            quant_code = 5'(-t);
            cy(2);
            `CHK(act, 1'b1)
            quant_code = 0;
        end
        acc(1, 12'h342, 8'h4F);
        acc(0, 12'h342, 8'h4F);
        quant_code = 4;
        cy(2);
        `CHK({act, rf}, 3'h5)
        rst_b = 0;
        cy(2);
        rst_b = 1;
        `CHK({act, stb, ofs}, 7'h00)
        acc(0, 12'h342, 8'hF5);
        acc(0, 12'h343, 8'hFF);
        finish_test();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
endmodule : tb_aes_shuffler
`default_nettype wire
